/* design/dac_defines.svh */
// Register offsets, field positions, reset values and decode constants of the
// double action timer channel.
// Assumes it is included by bare name from every file that needs it.
`ifndef DAC_DEFINES_SVH
`define DAC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets inside the channel
// ----------------------------------------------------------------------------
`define DAC_OFS_SIC     3'h0
`define DAC_OFS_DATA_A  3'h2
`define DAC_OFS_DATA_B  3'h4

// ----------------------------------------------------------------------------
// Status/control field positions
// ----------------------------------------------------------------------------
`define DAC_BIT_FLAG    15
`define DAC_BIT_IL_HI   14
`define DAC_BIT_IL_LO   12
`define DAC_BIT_ARB3    11
`define DAC_BIT_WOR     9
`define DAC_BIT_BSL     8
`define DAC_BIT_IN      7
`define DAC_BIT_FORCE_A_BIT   6
`define DAC_BIT_FORCE_B_BIT   5
`define DAC_BIT_EDGE_POLARITY_BIT   4
`define DAC_BIT_MODE_HI 3
`define DAC_BIT_MODE_LO 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DAC_RST_SIC     16'h0000
`define DAC_RST_DATA    16'h0000
`define DAC_IL_NONE     3'h0

// ----------------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------------
`define DAC_MODE_DIS    4'h0
`define DAC_MODE_IPW    4'h1
`define DAC_MODE_IPER   4'h2
`define DAC_MODE_ICAP   4'h3
`define DAC_MODE_OCB    4'h4
`define DAC_MODE_COMPARE_FLAG_ON_BOTH_MODE   4'h5

// ----------------------------------------------------------------------------
// Compare masks for the eight PWM resolutions
// ----------------------------------------------------------------------------
`define DAC_MASK_16     16'hFFFF
`define DAC_MASK_15     16'h7FFF
`define DAC_MASK_14     16'h3FFF
`define DAC_MASK_13     16'h1FFF
`define DAC_MASK_12     16'h0FFF
`define DAC_MASK_11     16'h07FF
`define DAC_MASK_9      16'h01FF
`define DAC_MASK_7      16'h007F

`endif

/* design/dac_pkg.sv */
// Types shared by the double action timer channel files.
// Assumes nothing beyond a SystemVerilog compiler.
package dac_pkg;

	// ------------------------------------------------------------------------
	// Operating mode classes
	// ------------------------------------------------------------------------
	typedef enum logic [6:0] {
		DAC_CLS_DIS  = 7'h01,
		DAC_CLS_IPW  = 7'h02,
		DAC_CLS_IPER = 7'h04,
		DAC_CLS_ICAP = 7'h08,
		DAC_CLS_OCB  = 7'h10,
		DAC_CLS_COMPARE_FLAG_ON_BOTH_MODE = 7'h20,
		DAC_CLS_PWM  = 7'h40
	} dac_class_e;

	// ------------------------------------------------------------------------
	// Register access request
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} dac_req_s;

	// ------------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic out;
		logic oe;
	} dac_pin_s;

	// ------------------------------------------------------------------------
	// Interrupt request towards the bus interface
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] level;
		logic [3:0] arb;
	} dac_irq_s;

endpackage : dac_pkg

/* design/dac_pin_sync.sv */
// Input pin synchroniser and edge detector for the timer channel.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module dac_pin_sync (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic pin_async,
	output logic      level_q,
	output logic      rise_q,
	output logic      fall_q
);

	logic [2:0] sync_q;
	logic       agree;
	logic       level_d;
	logic [2:0] fill_q;
	logic       primed;

	// ------------------------------------------------------------------------
	// Filter
	// ------------------------------------------------------------------------
	// A change only counts once the second and third stages agree, so a
	// metastable first stage never reaches the edge logic.
	assign agree   = sync_q[1] == sync_q[2];
	assign level_d = agree ? sync_q[2] : level_q;

	// Edges are held back until every stage holds a post-reset sample, so a
	// pulled-up pin does not look like a rising edge. An edge in the first
	// four cycles after reset is lost.
	assign primed  = fill_q == 3'h4;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync_q  <= 3'h0;
			fill_q  <= 3'h0;
			level_q <= 1'b0;
			rise_q  <= 1'b0;
			fall_q  <= 1'b0;
		end else begin
			sync_q  <= {sync_q[1:0], pin_async};
			fill_q  <= primed ? fill_q : fill_q + 3'h1;
			level_q <= level_d;
			rise_q  <= primed & level_d & ~level_q;
			fall_q  <= primed & ~level_d & level_q;
		end
	end

endmodule : dac_pin_sync

`default_nettype wire

/* design/dac_channel.sv */
// Double action timer channel: two 16-bit capture/compare channels on one pin.
// Assumes time-base buses and the arbitration low field arrive on clk_sys.
//
// Contract
// - Two 16-bit channels A and B capture or compare without software help.
// - One output flip-flop, set by one compare match, reset by the other.
// - Disabled mode turns the pin driver off.
// - Pulse-width mode captures on both leading and trailing edges.
// - Period mode captures on two consecutive edges of one polarity.
// - PWM resolution selectable as 7, 9, 11, 12, 13, 14, 15 or 16 bits.
// - Capture modes hold results in A and B2; B1 is a temporary latch.
// - Single-pulse compare uses A and B2 for the edges; B1 unused.
// - PWM software sees A and B1; hidden B2 double-buffers channel B.
// - Register transfers happen automatically; minimum pulse is one count.
// - Unused bits and unmapped offsets read zero; writes there do nothing.
// - Interrupt at programmed level when flag sets; level zero suppresses it.
// - Flag sets on every A capture; period mode skips the first.
// - Flag sets on B match, either match, A match in PWM; clears when disabled.
// - Flag clears by read-one then write-zero, unless a set intervened.
// - Arbitration bit three joins the low field; cleared by reset.
// - Open-drain select applies in output modes; reads back as written.
// - Bus select zero picks time base A, one picks time base B.
// - Pin status shows input level or polarised output; writes ignored.
// - Force A acts like an A match without flag; reads zero.
// - Force B acts like a B match without flag; both together reset.
// - Pulse-width polarity zero: A rising, B falling; one reverses.
// - Four-bit mode field decodes disabled, inputs, compares, and PWM.
// - Compare polarity zero: A match drives high, B low; one reverses.
// - A data write arms that channel's comparator until its next match.
`timescale 1ns/1ps
`default_nettype none

`include "dac_defines.svh"

module dac_channel (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire dac_pkg::dac_req_s req,
	output logic [15:0]           rdata_q,
	input  wire logic [15:0]      tb_a,
	input  wire logic [15:0]      tb_b,
	input  wire logic [2:0]       arb_low,
	input  wire logic             pin_in,
	output dac_pkg::dac_pin_s     pin_q,
	output dac_pkg::dac_irq_s     irq_q
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic        flag_q;
	logic [2:0]  il_q;
	logic        arb3_q;
	logic        wor_q;
	logic        bsl_q;
	logic        edge_polarity_bit_q;
	logic [3:0]  mode_q;
	logic [15:0] data_a_q;
	logic [15:0] b1_q;
	logic [15:0] b2_q;
	logic        arm_a_q;
	logic        arm_b_q;
	logic        ff_q;
	logic        clr_ok_q;
	logic        per_seen_q;

	logic        in_level;
	logic        in_rise;
	logic        in_fall;

	dac_pin_sync u_sync (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.pin_async (pin_in),
		.level_q   (in_level),
		.rise_q    (in_rise),
		.fall_q    (in_fall)
	);

	// ------------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------------
	dac_pkg::dac_class_e cls;
	logic                is_out;
	logic                is_pwm;
	logic                is_oc;
	logic                is_dis;

	assign cls = (mode_q[3])                     ? dac_pkg::DAC_CLS_PWM  :
	             (mode_q == `DAC_MODE_IPW)       ? dac_pkg::DAC_CLS_IPW  :
	             (mode_q == `DAC_MODE_IPER)      ? dac_pkg::DAC_CLS_IPER :
	             (mode_q == `DAC_MODE_ICAP)      ? dac_pkg::DAC_CLS_ICAP :
	             (mode_q == `DAC_MODE_OCB)       ? dac_pkg::DAC_CLS_OCB  :
	             (mode_q == `DAC_MODE_COMPARE_FLAG_ON_BOTH_MODE)      ? dac_pkg::DAC_CLS_COMPARE_FLAG_ON_BOTH_MODE :
	             dac_pkg::DAC_CLS_DIS;

	assign is_pwm = cls == dac_pkg::DAC_CLS_PWM;
	assign is_oc  = (cls == dac_pkg::DAC_CLS_OCB) || (cls == dac_pkg::DAC_CLS_COMPARE_FLAG_ON_BOTH_MODE);
	assign is_out = is_pwm || is_oc;
	assign is_dis = cls == dac_pkg::DAC_CLS_DIS;

	// ------------------------------------------------------------------------
	// Time base and compare
	// ------------------------------------------------------------------------
	logic [15:0] tb;
	logic [15:0] mask;
	logic        eq_a;
	logic        eq_b;
	logic        match_a;
	logic        match_b;

	assign tb = bsl_q ? tb_b : tb_a;

	always_comb begin
		mask = `DAC_MASK_16;
		if (is_pwm) begin
			unique case (mode_q[2:0])
				3'h0: mask = `DAC_MASK_16;
				3'h1: mask = `DAC_MASK_15;
				3'h2: mask = `DAC_MASK_14;
				3'h3: mask = `DAC_MASK_13;
				3'h4: mask = `DAC_MASK_12;
				3'h5: mask = `DAC_MASK_11;
				3'h6: mask = `DAC_MASK_9;
				3'h7: mask = `DAC_MASK_7;
			endcase
		end
	end

	assign eq_a = (tb & mask) == (data_a_q & mask);
	assign eq_b = (tb & mask) == (b2_q & mask);

	assign match_a = eq_a && ((is_oc && arm_a_q) || is_pwm);
	assign match_b = eq_b && ((is_oc && arm_b_q) || is_pwm);

	// ------------------------------------------------------------------------
	// Capture edges
	// ------------------------------------------------------------------------
	logic edge_a;
	logic edge_b;
	logic cap_ipw;
	logic cap_iper;
	logic cap_ic;

	assign edge_a = edge_polarity_bit_q ? in_fall : in_rise;
	assign edge_b = edge_polarity_bit_q ? in_rise : in_fall;

	assign cap_ipw  = cls == dac_pkg::DAC_CLS_IPW;
	assign cap_iper = cls == dac_pkg::DAC_CLS_IPER;
	assign cap_ic   = cls == dac_pkg::DAC_CLS_ICAP;

	// ------------------------------------------------------------------------
	// Register access decode
	// ------------------------------------------------------------------------
	logic wr_sic;
	logic wr_a;
	logic wr_b;
	logic rd_sic;
	logic b_uses_b1;

	assign wr_sic = req.wr && (req.addr == `DAC_OFS_SIC);
	assign wr_a   = req.wr && (req.addr == `DAC_OFS_DATA_A);
	assign wr_b   = req.wr && (req.addr == `DAC_OFS_DATA_B);
	assign rd_sic = req.rd && (req.addr == `DAC_OFS_SIC);

	assign b_uses_b1 = is_dis || is_pwm;

	// ------------------------------------------------------------------------
	// Force and output flip-flop
	// ------------------------------------------------------------------------
	logic force_a;
	logic force_b;
	logic set_ff;
	logic rst_ff;
	logic ff_d;
	logic pin_level;

	assign force_a = wr_sic && is_out && req.wdata[`DAC_BIT_FORCE_A_BIT];
	assign force_b = wr_sic && is_out && req.wdata[`DAC_BIT_FORCE_B_BIT];

	// set by A, reset by B
	assign set_ff = (match_a || force_a) && !(force_a && force_b);
	assign rst_ff = match_b || force_b;
	assign ff_d   = is_out ? (set_ff ? 1'b1 : (rst_ff ? 1'b0 : ff_q)) : ff_q;

	assign pin_level = ff_q ^ edge_polarity_bit_q;

	// ------------------------------------------------------------------------
	// Flag
	// ------------------------------------------------------------------------
	logic flag_set;
	logic flag_clr;
	logic flag_d;

	assign flag_set = ((cap_ipw || cap_ic) && edge_a) ||
	                  (cap_iper && edge_a && per_seen_q) ||
	                  ((cls == dac_pkg::DAC_CLS_OCB) && match_b) ||
	                  ((cls == dac_pkg::DAC_CLS_COMPARE_FLAG_ON_BOTH_MODE) && (match_a || match_b)) ||
	                  (is_pwm && match_a);

	assign flag_clr = wr_sic && !req.wdata[`DAC_BIT_FLAG] && clr_ok_q;

	// A set in the clear cycle wins; disabled mode forces the flag low.
	assign flag_d = is_dis ? 1'b0 : (flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_q));

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flag_q   <= 1'b0;
			clr_ok_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
			if (flag_set || wr_sic) begin
				clr_ok_q <= 1'b0;
			end else if (rd_sic && flag_q) begin
				clr_ok_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			il_q    <= `DAC_IL_NONE;
			arb3_q  <= 1'b0;
			wor_q   <= 1'b0;
			bsl_q   <= 1'b0;
			edge_polarity_bit_q <= 1'b0;
			mode_q  <= `DAC_MODE_DIS;
		end else if (wr_sic) begin
			il_q    <= req.wdata[`DAC_BIT_IL_HI:`DAC_BIT_IL_LO];
			arb3_q  <= req.wdata[`DAC_BIT_ARB3];
			wor_q   <= req.wdata[`DAC_BIT_WOR];
			bsl_q   <= req.wdata[`DAC_BIT_BSL];
			edge_polarity_bit_q <= req.wdata[`DAC_BIT_EDGE_POLARITY_BIT];
			mode_q  <= req.wdata[`DAC_BIT_MODE_HI:`DAC_BIT_MODE_LO];
		end
	end

	// ------------------------------------------------------------------------
	// Data registers, arming and captures
	// ------------------------------------------------------------------------
	logic [15:0] data_a_d;
	logic [15:0] b1_d;
	logic [15:0] b2_d;
	logic        arm_a_d;
	logic        arm_b_d;
	logic        per_seen_d;

	always_comb begin
		data_a_d   = data_a_q;
		b1_d       = b1_q;
		b2_d       = b2_q;
		arm_a_d    = arm_a_q && !match_a && is_oc;
		arm_b_d    = arm_b_q && !match_b && is_oc;
		per_seen_d = cap_iper && per_seen_q;
		if (cap_ipw && edge_b) begin
			b1_d = tb;
		end
		if (cap_ipw && edge_a) begin
			data_a_d = tb;
			b2_d     = b1_q;
		end
		if (cap_iper && edge_a) begin
			data_a_d   = tb;
			b2_d       = data_a_q;
			per_seen_d = 1'b1;
		end
		if (cap_ic && edge_a) begin
			data_a_d = tb;
		end
		if (cap_ic && edge_b) begin
			b2_d = tb;
		end
		if (is_pwm && match_a) begin
			b2_d = b1_q;
		end
		if (wr_a) begin
			data_a_d = req.wdata;
			arm_a_d  = is_oc;
		end
		if (wr_b) begin
			if (b_uses_b1) begin
				b1_d = req.wdata;
			end
			if (!is_pwm) begin
				b2_d = req.wdata;
			end
			arm_b_d = is_oc;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			data_a_q   <= `DAC_RST_DATA;
			b1_q       <= `DAC_RST_DATA;
			b2_q       <= `DAC_RST_DATA;
			arm_a_q    <= 1'b0;
			arm_b_q    <= 1'b0;
			per_seen_q <= 1'b0;
			ff_q       <= 1'b0;
		end else begin
			data_a_q   <= data_a_d;
			b1_q       <= b1_d;
			b2_q       <= b2_d;
			arm_a_q    <= arm_a_d;
			arm_b_q    <= arm_b_d;
			per_seen_q <= per_seen_d;
			ff_q       <= ff_d;
		end
	end

	// ------------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------------
	logic [15:0] sic_view;
	logic [15:0] rdata_d;
	logic        in_bit;

	assign in_bit = is_out ? pin_level : in_level;

	// reserved and force bits read zero
	assign sic_view = {flag_q, il_q, arb3_q, 1'b0, wor_q, bsl_q, in_bit, 2'h0, edge_polarity_bit_q, mode_q};

	assign rdata_d = !req.rd                        ? rdata_q :
	                 (req.addr == `DAC_OFS_SIC)     ? sic_view :
	                 (req.addr == `DAC_OFS_DATA_A)  ? data_a_q :
	                 (req.addr == `DAC_OFS_DATA_B)  ? (b_uses_b1 ? b1_q : b2_q) :
	                 16'h0000;

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	logic pin_oe_d;
	logic [2:0] irq_level_d;

	assign pin_oe_d = is_out && (!wor_q || !pin_level);

	assign irq_level_d = flag_q ? il_q : `DAC_IL_NONE;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q   <= 16'h0000;
			pin_q     <= '0;
			irq_q     <= '0;
		end else begin
			rdata_q   <= rdata_d;
			pin_q.out <= pin_level;
			pin_q.oe  <= pin_oe_d;
			irq_q.level <= irq_level_d;
			irq_q.arb <= {arb3_q, arb_low};
		end
	end

endmodule : dac_channel

`default_nettype wire

/* test/dac_checker.sv */
// Port checker for the double action timer channel.
// Assumes it is bound to dac_channel and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module dac_checker (
	input wire logic              clk_sys,
	input wire logic              reset_n,
	input wire dac_pkg::dac_req_s req,
	input wire logic [15:0]       rdata_q,
	input wire logic [2:0]        arb_low,
	input wire dac_pkg::dac_pin_s pin_q,
	input wire dac_pkg::dac_irq_s irq_q
);
	// ----------------------------------------------------------------
	// Shadow of the written control register
	// ----------------------------------------------------------------
	logic [15:0] sic_q;
	wire         sic_wr   = req.wr && req.addr == 3'h0;
	wire  [3:0]  wm       = req.wdata[3:0];
	wire         w_out    = wm[3] || wm == 4'h4 || wm == 4'h5;
	wire         ctl_same = wm == sic_q[3:0];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			sic_q <= 16'h0000;
		else if (sic_wr)
			sic_q <= req.wdata;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Forces only count when the mode is not changed by the same write.
	sequence s_force(logic [1:0] f);
		sic_wr && w_out && ctl_same && req.wdata[6:5] == f;
	endsequence

	property p_unmapped;
		req.rd && !(req.addr inside {3'h0, 3'h2, 3'h4}) |=> rdata_q == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_sic_zero;
		req.rd && req.addr == 3'h0 |=> rdata_q[10] == 1'b0 && rdata_q[6:5] == 2'b00;
	endproperty
	a_sic_zero: assert property (p_sic_zero) else $error("reserved or force bits read one");

	property p_dis_float;
		sic_q[3:0] == 4'h0 && $past(sic_q[3:0]) == 4'h0 |-> !pin_q.oe;
	endproperty
	a_dis_float: assert property (p_dis_float) else $error("pin driven while disabled");

	property p_arb;
		$past(reset_n) |-> irq_q.arb == {$past(sic_q[11]), $past(arb_low)};
	endproperty
	a_arb: assert property (p_arb) else $error("arbitration number wrong");

	property p_irq_level;
		irq_q.level != 3'h0 |-> irq_q.level == $past(sic_q[14:12]);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("request at wrong level");

	property p_force_a;
		s_force(2'b10) |-> ##2 pin_q.out == !sic_q[4];
	endproperty
	a_force_a: assert property (p_force_a) else $error("force A did not set output");

	property p_force_rst;
		(s_force(2'b01) or s_force(2'b11)) |-> ##2 pin_q.out == sic_q[4];
	endproperty
	a_force_rst: assert property (p_force_rst) else $error("force B did not reset output");

	property p_open_drain;
		sic_q[9] && $past(sic_q[9]) && $past(sic_q[9], 2) |-> !(pin_q.oe && pin_q.out);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
endmodule : dac_checker

bind dac_channel dac_checker u_chk (
	.clk_sys(clk_sys),
	.reset_n(reset_n),
	.req    (req),
	.rdata_q(rdata_q),
	.arb_low(arb_low),
	.pin_q  (pin_q),
	.irq_q  (irq_q)
);

`default_nettype wire

/* test/dac_pin_model.sv */
// Outside party on the timer pin: a driver that the bench controls.
// Assumes a pull-up on the pin, so a released pin reads high.
`timescale 1ns/1ps
`default_nettype none

module dac_pin_model (
	input wire dac_pkg::dac_pin_s pin_q,
	input wire logic              ext_en,
	input wire logic              ext_lvl,
	output logic                  pin_in
);
	// The channel wins only while it drives; otherwise the outside or the pull-up.
	assign pin_in = pin_q.oe ? pin_q.out : (ext_en ? ext_lvl : 1'b1);
endmodule : dac_pin_model

`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the double action timer channel.
// Assumes both time bases count once per clk_sys and the pin has a pull-up.
`timescale 1ns/1ps
`default_nettype none

`include "dac_defines.svh"

module tb_top;
	logic              clk_sys     = 1'b0;
	logic              reset_n     = 1'b0;
	dac_pkg::dac_req_s req         = '0;
	logic [15:0]       tb_a        = 16'h0000;
	logic [15:0]       tb_b        = 16'h5000;
	logic [2:0]        arb_low     = 3'h0;
	logic              ext_en      = 1'b0;
	logic              ext_lvl     = 1'b1;
	logic              bsl_v       = 1'b0;
	logic [1:0]        fz [4]      = '{2'b10, 2'b01, 2'b10, 2'b11};
	logic [15:0]       rdata_q;
	logic              pin_in;
	dac_pkg::dac_pin_s pin_q;
	dac_pkg::dac_irq_s irq_q;
	logic [15:0]       rd_v;
	logic [15:0]       t0;
	int                exp_len [$];
	int                err_count   = 0;
	int                comparisons = 0;
	int                cycles      = 0;

	dac_channel DUT (.clk_sys(clk_sys), .reset_n(reset_n), .req(req), .rdata_q(rdata_q), .tb_a(tb_a),
		.tb_b(tb_b), .arb_low(arb_low), .pin_in(pin_in), .pin_q(pin_q), .irq_q(irq_q));
	dac_pin_model u_pin (.pin_q(pin_q), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in));

	always #12.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		tb_a <= tb_a + 16'h0001;
		tb_b <= tb_b + 16'h0001;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			$display("MISMATCH t=%0t run too long", $time);
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_sys);
		req <= '0;
		#1 rd_v = rdata_q;
	endtask : bus

	// Edges are spaced by whole cycles so capture differences are exact.
	task automatic edge_to(input logic v, input int gap);
		@(posedge clk_sys);
		ext_en <= 1'b1;
		ext_lvl <= v;
		t0 = bsl_v ? tb_b : tb_a;
		tick(gap);
	endtask : edge_to

	task automatic wait_bus(input logic [15:0] x, input logic [15:0] m);
		int n;
		n = 0;
		while ((tb_a & m) !== x && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		if ((tb_a & m) !== x) begin
			err_count++;
			$display("MISMATCH t=%0t time base never reached %h", $time, x);
		end
		#1;
	endtask : wait_bus

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	function automatic logic [15:0] sic(input logic [2:0] il, input logic time_base_bus_select, input logic pol, input logic [3:0] m);
		return {1'b0, il, 3'h0, time_base_bus_select, 3'h0, pol, m};
	endfunction : sic

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] w;
		logic [15:0] a;
		logic [15:0] b;
		int          l;
		void'($urandom(65));
		tick(5);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			if (!(i inside {0, 2, 4}))
				bus(1'b1, 3'(i), 16'hFFFF);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 3'(i), 16'h0000);
			chk(rd_v, (i == 0) ? 16'h0080 : 16'h0000, "reset or unmapped");
		end
		done("registers");
		repeat (4) begin
			w = 16'($urandom) & 16'hFFF0;
			@(posedge clk_sys);
			arb_low <= 3'($urandom);
			bus(1'b1, 3'h0, w);
			bus(1'b0, 3'h0, 16'h0000);
			chk(rd_v, (w & 16'h7B10) | 16'h0080, "control readback");
			chk(16'(irq_q), {12'h000, w[11], arb_low}, "arbitration");
		end
		done("control");
		for (int k = 0; k < 2; k++) begin
			bsl_v = k[0];
			l = 3 + int'($urandom % 20);
			exp_len.push_back(l + 1);
			bus(1'b1, 3'h0, 16'h0000);
			edge_to(!k[0], 8);
			w = sic(3'h3, k[0], k[0], `DAC_MODE_IPW);
			bus(1'b1, 3'h0, w);
			tick(8);
			edge_to(k[0], l);
			edge_to(!k[0], 12);
			bus(1'b0, 3'h2, 16'h0000);
			a = rd_v;
			bus(1'b0, 3'h4, 16'h0000);
			b = rd_v;
			chk(a - b, 16'(exp_len.pop_front()), "pulse width");
			chk(16'((a - t0) inside {[16'h0001:16'h0009]}), 16'h0001, "capture bus");
			bus(1'b0, 3'h0, 16'h0000);
			chk(rd_v, w | 16'h8000 | {8'h00, !k[0], 7'h00}, "flag and pin");
			chk(16'(irq_q.level), 16'h0003, "irq level");
			bus(1'b1, 3'h0, w);
			bus(1'b0, 3'h0, 16'h0000);
			chk(16'(rd_v[15] | (|irq_q.level)), 16'h0000, "flag clear");
		end
		done("pulse width");
		bsl_v = 1'b0;
		bus(1'b1, 3'h0, 16'h0000);
		edge_to(1'b0, 8);
		w = sic(3'h2, 1'b0, 1'b0, `DAC_MODE_IPER);
		bus(1'b1, 3'h0, w);
		tick(8);
		edge_to(1'b1, 10);
		bus(1'b0, 3'h0, 16'h0000);
		chk(16'(rd_v[15]), 16'h0000, "first period edge");
		edge_to(1'b0, 6);
		edge_to(1'b1, 12);
		bus(1'b0, 3'h2, 16'h0000);
		a = rd_v;
		bus(1'b0, 3'h4, 16'h0000);
		chk(a - rd_v, 16'h0014, "period");
		bus(1'b0, 3'h0, 16'h0000);
		edge_to(1'b0, 4);
		edge_to(1'b1, 10);
		bus(1'b1, 3'h0, w);
		bus(1'b0, 3'h0, 16'h0000);
		chk(16'(rd_v[15]), 16'h0001, "set between read and write");
		bus(1'b1, 3'h0, w);
		bus(1'b0, 3'h0, 16'h0000);
		chk(16'(rd_v[15]), 16'h0000, "clear after read");
		bus(1'b1, 3'h0, 16'h0000);
		w = sic(3'h0, 1'b0, 1'b0, `DAC_MODE_ICAP);
		bus(1'b1, 3'h0, w);
		edge_to(1'b0, 10);
		edge_to(1'b1, 10);
		bus(1'b0, 3'h2, 16'h0000);
		a = rd_v;
		bus(1'b0, 3'h4, 16'h0000);
		chk(a - rd_v, 16'h000B, "edge capture");
		bus(1'b0, 3'h0, 16'h0000);
		chk(16'(rd_v[15]), 16'h0001, "edge capture flag");
		bus(1'b1, 3'h0, 16'h0000);
		done("period");
		@(posedge clk_sys);
		ext_en <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			w = sic(3'h1, 1'b0, k[0], k[0] ? `DAC_MODE_COMPARE_FLAG_ON_BOTH_MODE : `DAC_MODE_OCB) | {6'h00, k[0], 9'h000};
			bus(1'b1, 3'h0, w);
			a = tb_a + 16'h0020;
			bus(1'b1, 3'h2, a);
			bus(1'b1, 3'h4, a + 16'h001E);
			wait_bus(a + 16'h000F, 16'hFFFF);
			chk(16'(pin_q), {14'h0000, !k[0], 1'b1}, "leading edge");
			bus(1'b0, 3'h0, 16'h0000);
			chk(16'(rd_v[15]), 16'(k), "flag on A");
			wait_bus(a + 16'h002D, 16'hFFFF);
			chk(16'(pin_q), {14'h0000, k[0], !k[0]}, "trailing edge");
			bus(1'b0, 3'h0, 16'h0000);
			chk(16'(rd_v[15]), 16'h0001, "flag on B");
			bus(1'b1, 3'h0, 16'h0000);
		end
		w = sic(3'h0, 1'b0, 1'b0, `DAC_MODE_COMPARE_FLAG_ON_BOTH_MODE);
		bus(1'b1, 3'h0, w);
		foreach (fz[i]) begin
			bus(1'b1, 3'h0, w | {9'h000, fz[i], 5'h00});
			tick(2);
			#1;
			chk(16'(pin_q.out), 16'(fz[i] == 2'b10), "force");
		end
		bus(1'b0, 3'h0, 16'h0000);
		chk(rd_v, w, "force leaves flag");
		done("compare");
		for (int m = 8; m < 16; m++) begin
			bus(1'b1, 3'h0, sic(3'h0, 1'b0, 1'b0, 4'(m)));
			bus(1'b0, 3'h0, 16'h0000);
			chk(rd_v & 16'h7F7F, 16'(m), "pwm mode");
		end
		bus(1'b1, 3'h2, 16'h0010);
		bus(1'b1, 3'h4, 16'h0050);
		tick(130);
		wait_bus(16'h0030, 16'h007F);
		chk(16'(pin_q.out), 16'h0001, "pwm high");
		// A new B value written mid-period must wait for the next A match.
		bus(1'b1, 3'h4, 16'h0020);
		wait_bus(16'h0060, 16'h007F);
		chk(16'(pin_q.out), 16'h0000, "pwm low");
		bus(1'b0, 3'h0, 16'h0000);
		chk(16'(rd_v[15]), 16'h0001, "pwm flag");
		wait_bus(16'h0030, 16'h007F);
		chk(16'(pin_q.out), 16'h0000, "pwm reload");
		bus(1'b1, 3'h0, 16'h0000);
		done("pwm");
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
